// *** hdl/can_pm_time.sv ***
// Overview of operation
// - Request write enters power-down, sets acknowledge
// - Power-down reads: status 0x08, others zero
// - Exit on POWER_DOWN_REQUEST clear or enabled bus activity
// - Bus wake waits 11 recessive bits
// - Frame that wakes the module is lost
// - Wake clears request, ack; error counters untouched
// - Finish ongoing frame before acknowledging power-down
// - Bus-off standby sets config request on wake
// - Always-on wake logic; module clock gated
// - System low-power request stops all clocks
// - Low-power during transmit: wake flag, finish frame
// - Dominant bus in global sleep sets wake flag
// - Time scanner yields to protocol engine
// - 32-bit counter stamped into mailbox on events
// - Counter ticks on bit clock, halts in init, suspend or power-down
// - MSB-clear write clears counter MSB only
// - Sync mailbox event clears counter when enabled
// - Counter readable outside power-down, writable privileged only
// - Counter MSB rising sets overflow flag
// - Time-out flag on enable, limit, receive mailbox or pending request
// - Time-out flag cleared by enable or request drop
// - Writing one clears time-out flag
// - Time-out raises alarm on selected line
`timescale 1ns/1ps
module can_pm_time #(
  parameter int unsigned NMB     = 32,
  parameter int unsigned SYNC_MB = 16
) (
  input  wire logic                    i_ref_clk,
  input  wire logic                    i_rst,
  input  wire can_pm_pkg::apb_req_t    i_apb,
  input  wire can_pm_pkg::kernel_evt_t i_kernel,
  input  wire logic                    i_bus_rx_pin,
  input  wire logic                    i_system_low_power_request,
  output logic [31:0]                  o_prdata,
  output logic                         o_pready,
  output logic                         o_pslverr,
  output logic                         o_module_clk_en,
  output logic                         o_global_clk_off,
  output logic                         o_bus_active,
  output logic                         o_rx_discard,
  output logic                         o_change_config_request,
  output logic [NMB-1:0]               o_transmit_request,
  output logic [1:0]                   o_int_line
);

  localparam int unsigned IDXW = $clog2(NMB);

  typedef enum logic [1:0] {PM_RUN, PM_SLEEP, PM_WAKE} pm_state_t;
  typedef enum logic [1:0] {GP_RUN, GP_DRAIN, GP_OFF} gp_state_t;

  typedef struct packed {
    pm_state_t             pm;
    gp_state_t             gp;
    logic [31:0]           mc;
    logic [31:0]           gim;
    logic [31:0]           gif0;
    logic [31:0]           gif1;
    logic [31:0]           local_network_time;
    logic [NMB-1:0]        md;
    logic [NMB-1:0]        transmit_request;
    logic [NMB-1:0]        mailbox_interrupt_level;
    logic [NMB-1:0]        timeout_enable_bits;
    logic [NMB-1:0]        timeout_flag_bits;
    logic [NMB-1:0][31:0]  mailbox_time_stamp;
    logic [NMB-1:0][31:0]  mailbox_timeout_limit;
    logic                  power_down_ack;
    logic                  off_at_sleep;
    logic [3:0]            rec_cnt;
    logic [IDXW-1:0]       scan;
    logic                  rx_s1;
    logic                  rx_s2;
    logic                  pready;
    logic                  pslverr;
    logic [31:0]           prdata;
    logic                  clk_en;
    logic                  gclk_off;
    logic                  bus_active;
    logic [1:0]            int_line;
  } state_t;

  state_t state_reg;
  state_t state_next;

  function automatic logic [31:0] ext32(input logic [NMB-1:0] v);
    logic [31:0] r;
    r          = '0;
    r[NMB-1:0] = v;
    return r;
  endfunction : ext32

  // Interrupt line is live when any masked flag of that line is set
  function automatic logic irq_any(input logic [31:0] flags, input logic [31:0] mask);
    return |(flags & mask & can_pm_pkg::GIF_W1C);
  endfunction : irq_any

  // Selects flag register by level bit, sets one flag there
  function automatic logic [63:0] set_flag(input logic [31:0] f0, input logic [31:0] f1,
                                           input logic lvl, input int unsigned bitpos);
    logic [31:0] a;
    logic [31:0] b;
    a = f0;
    b = f1;
    if (lvl) begin
      b[bitpos] = 1'b1;
    end else begin
      a[bitpos] = 1'b1;
    end
    return {b, a};
  endfunction : set_flag

  always_comb begin
    logic [31:0]     rd;
    logic            hit;
    logic            wr;
    logic [31:0]     wd;
    logic [IDXW-1:0] widx;
    logic [IDXW-1:0] kidx;
    logic [IDXW-1:0] sidx;
    logic            lnt_run;
    logic            sync_hit;
    logic            timed_out;
    rd         = '0;
    hit        = 1'b1;
    wd         = i_apb.pwdata;
    widx       = i_apb.paddr[IDXW+1:2];
    kidx       = i_kernel.mb_idx[IDXW-1:0];
    sidx       = state_reg.scan;
    lnt_run    = 1'b0;
    sync_hit   = 1'b0;
    timed_out  = 1'b0;
    state_next = state_reg;

    state_next.rx_s1   = i_bus_rx_pin;
    state_next.rx_s2   = state_reg.rx_s1;
    state_next.pready  = 1'b0;
    state_next.pslverr = 1'b0;

    // Read decode
    case (i_apb.paddr)
      can_pm_pkg::OFF_MD:   rd = ext32(state_reg.md);
      can_pm_pkg::OFF_TRS:  rd = ext32(state_reg.transmit_request);
      can_pm_pkg::OFF_MC:   rd = state_reg.mc;
      can_pm_pkg::OFF_ES: begin
        rd                     = '0;
        rd[can_pm_pkg::ES_PDA] = state_reg.power_down_ack;
        rd[can_pm_pkg::ES_CCE] = i_kernel.cce;
        rd[can_pm_pkg::ES_BO]  = i_kernel.bus_off;
      end
      can_pm_pkg::OFF_GIF0: rd = state_reg.gif0;
      can_pm_pkg::OFF_GIM:  rd = state_reg.gim;
      can_pm_pkg::OFF_GIF1: rd = state_reg.gif1;
      can_pm_pkg::OFF_MIL:  rd = ext32(state_reg.mailbox_interrupt_level);
      can_pm_pkg::OFF_LNT:  rd = state_reg.local_network_time;
      can_pm_pkg::OFF_TOC:  rd = ext32(state_reg.timeout_enable_bits);
      can_pm_pkg::OFF_TOS:  rd = ext32(state_reg.timeout_flag_bits);
      default: begin
        if (i_apb.paddr[11:8] == can_pm_pkg::PAGE_MAILBOX_TIME_STAMP && 32'(widx) < NMB) begin
          rd = state_reg.mailbox_time_stamp[widx];
        end else if (i_apb.paddr[11:8] == can_pm_pkg::PAGE_MAILBOX_TIMEOUT_LIMIT && 32'(widx) < NMB) begin
          rd = state_reg.mailbox_timeout_limit[widx];
        end else begin
          hit = 1'b0;
        end
      end
    endcase
    // Base clock is off: only the status word answers
    if (state_reg.power_down_ack) begin
      rd = (i_apb.paddr == can_pm_pkg::OFF_ES) ? can_pm_pkg::ES_PD_READ : '0;
    end

    // No wait state; read data comes from a flop loaded in the setup cycle
    if (i_apb.psel && !i_apb.penable && !state_reg.pready) begin
      state_next.pready  = 1'b1;
      state_next.pslverr = !hit;
      state_next.prdata  = rd;
    end
    wr = i_apb.psel && i_apb.penable && i_apb.pwrite && state_reg.pready
         && !state_reg.pslverr;

    // Register writes; while asleep only control word writes land
    if (wr && i_apb.paddr == can_pm_pkg::OFF_MC) begin
      state_next.mc                     = wd;
      state_next.mc[can_pm_pkg::MC_TIME_MSB_CLEAR] = 1'b0;
      if (wd[can_pm_pkg::MC_TIME_MSB_CLEAR]) begin
        state_next.local_network_time[31] = 1'b0;
      end
    end
    if (wr && !state_reg.power_down_ack) begin
      case (i_apb.paddr)
        can_pm_pkg::OFF_MD:   state_next.md  = wd[NMB-1:0];
        can_pm_pkg::OFF_TRS:  state_next.transmit_request = state_reg.transmit_request | wd[NMB-1:0];
        can_pm_pkg::OFF_GIF0: state_next.gif0 = state_reg.gif0 & ~(wd & can_pm_pkg::GIF_W1C);
        can_pm_pkg::OFF_GIM:  state_next.gim = wd;
        can_pm_pkg::OFF_GIF1: state_next.gif1 = state_reg.gif1 & ~(wd & can_pm_pkg::GIF_W1C);
        can_pm_pkg::OFF_MIL:  state_next.mailbox_interrupt_level = wd[NMB-1:0];
        can_pm_pkg::OFF_LNT: begin
          if (i_apb.pprot[0]) begin
            state_next.local_network_time = wd;
          end
        end
        can_pm_pkg::OFF_TOC:  state_next.timeout_enable_bits = wd[NMB-1:0];
        can_pm_pkg::OFF_TOS:  state_next.timeout_flag_bits = state_reg.timeout_flag_bits & ~wd[NMB-1:0];
        default: begin
          if (i_apb.paddr[11:8] == can_pm_pkg::PAGE_MAILBOX_TIME_STAMP && 32'(widx) < NMB) begin
            state_next.mailbox_time_stamp[widx] = wd;
          end else if (i_apb.paddr[11:8] == can_pm_pkg::PAGE_MAILBOX_TIMEOUT_LIMIT && 32'(widx) < NMB) begin
            state_next.mailbox_timeout_limit[widx] = wd;
          end
        end
      endcase
    end

    // Kernel ends a transmit request; a CPU set in the same cycle wins
    if (i_kernel.tx_done && 32'(i_kernel.mb_idx) < NMB) begin
      state_next.transmit_request[kidx] = 1'b0;
      if (wr && i_apb.paddr == can_pm_pkg::OFF_TRS && !state_reg.power_down_ack) begin
        state_next.transmit_request[kidx] = wd[kidx];
      end
      if (!state_reg.md[kidx]) begin
        state_next.timeout_flag_bits[kidx] = 1'b0;
      end
    end
    state_next.timeout_flag_bits = state_next.timeout_flag_bits & state_next.timeout_enable_bits;

    // Stamp and sync clear use the value before this cycle's tick
    sync_hit = 1'b0;
    if (32'(i_kernel.mb_idx) < NMB) begin
      if (i_kernel.rx_store || (i_kernel.tx_done && i_kernel.tx_ok)) begin
        state_next.mailbox_time_stamp[kidx] = state_reg.local_network_time;
      end
      if (32'(i_kernel.mb_idx) == SYNC_MB) begin
        sync_hit = (i_kernel.rx_store && state_reg.md[kidx])
                   || (i_kernel.tx_done && i_kernel.tx_ok && !state_reg.md[kidx]);
      end
    end
    lnt_run = i_kernel.bit_tick && !i_kernel.init_mode && !i_kernel.suspend
              && state_reg.pm == PM_RUN && state_reg.gp != GP_OFF;
    if (state_reg.mc[can_pm_pkg::MC_TIME_CLEAR_ON_SYNC_MAILBOX] && sync_hit) begin
      state_next.local_network_time = '0;
    end else if (lnt_run && !(wr && i_apb.paddr == can_pm_pkg::OFF_LNT)) begin
      state_next.local_network_time = state_next.local_network_time + 32'h0000_0001;
    end
    if (!state_reg.local_network_time[31] && state_next.local_network_time[31]) begin
      {state_next.gif1, state_next.gif0} = set_flag(state_next.gif0, state_next.gif1,
          state_reg.gim[can_pm_pkg::GI_SIL], can_pm_pkg::GI_TCO);
    end

    // One mailbox compared per free cycle; protocol engine has the RAM first
    if (!i_kernel.kernel_busy && state_reg.pm == PM_RUN) begin
      timed_out = state_reg.timeout_enable_bits[sidx] && (state_reg.local_network_time >= state_reg.mailbox_timeout_limit[sidx])
                  && (state_reg.md[sidx] || state_reg.transmit_request[sidx]);
      if (timed_out && state_next.timeout_enable_bits[sidx]) begin
        if (!state_reg.timeout_flag_bits[sidx] && state_reg.gim[can_pm_pkg::GI_MA]) begin
          {state_next.gif1, state_next.gif0} = set_flag(state_next.gif0, state_next.gif1,
              state_reg.mailbox_interrupt_level[sidx], can_pm_pkg::GI_MA);
        end
        state_next.timeout_flag_bits[sidx] = 1'b1;
      end
      state_next.scan = (32'(sidx) == NMB - 1) ? '0 : IDXW'(32'(sidx) + 1);
    end

    // Local power-down; wake logic runs on the always-on domain
    case (state_reg.pm)
      PM_RUN: begin
        // Ack waits for the current frame to end, so no bus error
        if (state_reg.mc[can_pm_pkg::MC_PDR] && !i_kernel.tx_busy) begin
          state_next.pm           = PM_SLEEP;
          state_next.power_down_ack          = 1'b1;
          state_next.clk_en       = 1'b0;
          state_next.bus_active   = 1'b0;
          state_next.off_at_sleep = i_kernel.bus_off;
        end
      end
      PM_SLEEP: begin
        if (!state_next.mc[can_pm_pkg::MC_PDR]) begin
          state_next.pm         = PM_RUN;
          state_next.power_down_ack        = 1'b0;
          state_next.clk_en     = 1'b1;
          state_next.bus_active = 1'b1;
          if (state_reg.off_at_sleep) begin
            state_next.mc[can_pm_pkg::MC_CCR] = 1'b1;
          end
        end else if (state_reg.mc[can_pm_pkg::MC_WAKE_ON_BUS_ACTIVITY] && !state_reg.rx_s2) begin
          state_next.pm                     = PM_WAKE;
          state_next.power_down_ack                    = 1'b0;
          state_next.mc[can_pm_pkg::MC_PDR] = 1'b0;
          state_next.clk_en                 = 1'b1;
          state_next.rec_cnt                = '0;
          if (state_reg.off_at_sleep) begin
            state_next.mc[can_pm_pkg::MC_CCR] = 1'b1;
          end
        end
      end
      PM_WAKE: begin
        // Waking frame is thrown away while recessive bits are counted
        if (i_kernel.bit_tick) begin
          if (!state_reg.rx_s2) begin
            state_next.rec_cnt = '0;
          end else if (state_reg.rec_cnt == can_pm_pkg::RECESSIVE_N - 4'h1) begin
            state_next.pm         = PM_RUN;
            state_next.bus_active = 1'b1;
            state_next.rec_cnt    = '0;
          end else begin
            state_next.rec_cnt = state_reg.rec_cnt + 4'h1;
          end
        end
      end
      default: state_next.pm = PM_RUN;
    endcase

    // Global power-down under the system request
    case (state_reg.gp)
      GP_RUN: begin
        if (i_system_low_power_request) begin
          if (i_kernel.tx_busy) begin
            state_next.gp = GP_DRAIN;
            if (state_reg.gim[can_pm_pkg::GI_WU]) begin
              {state_next.gif1, state_next.gif0} = set_flag(state_next.gif0, state_next.gif1,
                  state_reg.gim[can_pm_pkg::GI_SIL], can_pm_pkg::GI_WU);
            end
          end else begin
            state_next.gp       = GP_OFF;
            state_next.gclk_off = 1'b1;
          end
        end
      end
      GP_DRAIN: begin
        if (!i_system_low_power_request) begin
          state_next.gp = GP_RUN;
        end else if (!i_kernel.tx_busy) begin
          state_next.gp       = GP_OFF;
          state_next.gclk_off = 1'b1;
        end
      end
      GP_OFF: begin
        // No filtering: any dominant sample raises the flag
        if (!state_reg.rx_s2) begin
          {state_next.gif1, state_next.gif0} = set_flag(state_next.gif0, state_next.gif1,
              state_reg.gim[can_pm_pkg::GI_SIL], can_pm_pkg::GI_WU);
        end
        if (!i_system_low_power_request) begin
          state_next.gp       = GP_RUN;
          state_next.gclk_off = 1'b0;
        end
      end
      default: state_next.gp = GP_RUN;
    endcase

    state_next.int_line[0] = state_reg.gim[can_pm_pkg::GI_I0EN]
                             && irq_any(state_reg.gif0, state_reg.gim);
    state_next.int_line[1] = state_reg.gim[can_pm_pkg::GI_I1EN]
                             && irq_any(state_reg.gif1, state_reg.gim);
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg            <= '0;
      state_reg.pm         <= PM_RUN;
      state_reg.gp         <= GP_RUN;
      state_reg.mc         <= can_pm_pkg::MC_RST;
      state_reg.local_network_time        <= can_pm_pkg::LNT_RST;
      state_reg.rx_s1      <= 1'b1;
      state_reg.rx_s2      <= 1'b1;
      state_reg.clk_en     <= 1'b1;
      state_reg.bus_active <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_prdata                = state_reg.prdata;
  assign o_pready                = state_reg.pready;
  assign o_pslverr               = state_reg.pslverr;
  assign o_module_clk_en         = state_reg.clk_en;
  assign o_global_clk_off        = state_reg.gclk_off;
  assign o_bus_active            = state_reg.bus_active;
  assign o_rx_discard            = state_reg.pm != PM_RUN;
  assign o_change_config_request = state_reg.mc[can_pm_pkg::MC_CCR];
  assign o_transmit_request      = state_reg.transmit_request;
  assign o_int_line              = state_reg.int_line;

endmodule : can_pm_time

// *** inc/can_pm_pkg.sv ***
package can_pm_pkg;

  localparam int unsigned ADDR_W = 12;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_MD   = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_TRS  = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_MC   = 12'h028;
  localparam logic [ADDR_W-1:0] OFF_ES   = 12'h030;
  localparam logic [ADDR_W-1:0] OFF_GIF0 = 12'h03C;
  localparam logic [ADDR_W-1:0] OFF_GIM  = 12'h040;
  localparam logic [ADDR_W-1:0] OFF_GIF1 = 12'h044;
  localparam logic [ADDR_W-1:0] OFF_MIL  = 12'h04C;
  localparam logic [ADDR_W-1:0] OFF_LNT  = 12'h05C;
  localparam logic [ADDR_W-1:0] OFF_TOC  = 12'h060;
  localparam logic [ADDR_W-1:0] OFF_TOS  = 12'h064;
  // Per-mailbox arrays, one word per mailbox
  localparam logic [3:0]        PAGE_MAILBOX_TIME_STAMP = 4'h1;
  localparam logic [3:0]        PAGE_MAILBOX_TIMEOUT_LIMIT = 4'h2;

  // Master control fields
  localparam int unsigned MC_WAKE_ON_BUS_ACTIVITY = 9;
  localparam int unsigned MC_PDR  = 11;
  localparam int unsigned MC_CCR  = 12;
  localparam int unsigned MC_TIME_MSB_CLEAR = 14;
  localparam int unsigned MC_TIME_CLEAR_ON_SYNC_MAILBOX = 15;

  // Error status fields
  localparam int unsigned ES_PDA = 3;
  localparam int unsigned ES_CCE = 4;
  localparam int unsigned ES_BO  = 18;

  // Interrupt flag and mask fields
  localparam int unsigned GI_I0EN = 0;
  localparam int unsigned GI_I1EN = 1;
  localparam int unsigned GI_SIL  = 2;
  localparam int unsigned GI_WU   = 12;
  localparam int unsigned GI_TCO  = 16;
  localparam int unsigned GI_MA   = 17;

  localparam logic [31:0] GIF_W1C     = 32'h0003_1000;
  localparam logic [31:0] ES_PD_READ  = 32'h0000_0008;
  localparam logic [31:0] MC_RST      = 32'h0000_0000;
  localparam logic [31:0] LNT_RST     = 32'h0000_0000;
  localparam logic [3:0]  RECESSIVE_N = 4'hB;

  typedef struct packed {
    logic                psel;
    logic                penable;
    logic                pwrite;
    logic [ADDR_W-1:0]   paddr;
    logic [31:0]         pwdata;
    logic [2:0]          pprot;
  } apb_req_t;

  typedef struct packed {
    logic                tx_busy;
    logic                tx_done;
    logic                tx_ok;
    logic                rx_store;
    logic [4:0]          mb_idx;
    logic                bit_tick;
    logic                bus_off;
    logic                cce;
    logic                init_mode;
    logic                suspend;
    logic                kernel_busy;
  } kernel_evt_t;

endpackage : can_pm_pkg

// *** dv/can_pm_time_asserts.sv ***
`timescale 1ns/1ps
module can_pm_time_asserts #(
  parameter int unsigned NMB = 32
) (
  input wire logic                    i_ref_clk,
  input wire logic                    i_rst,
  input wire can_pm_pkg::apb_req_t    i_apb,
  input wire can_pm_pkg::kernel_evt_t i_kernel,
  input wire logic                    i_system_low_power_request,
  input wire logic [31:0]             o_prdata,
  input wire logic                    o_pready,
  input wire logic                    o_pslverr,
  input wire logic                    o_module_clk_en,
  input wire logic                    o_global_clk_off,
  input wire logic                    o_bus_active,
  input wire logic                    o_rx_discard,
  input wire logic [NMB-1:0]          o_transmit_request
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  sequence s_rd_asleep;
    i_apb.psel && !i_apb.penable && !i_apb.pwrite && !o_module_clk_en;
  endsequence
  a_sleep_reads_zero: assert property (s_rd_asleep ##0 (i_apb.paddr != can_pm_pkg::OFF_ES)
    |=> o_prdata == 32'h0000_0000) else $error("read not masked in sleep");
  a_sleep_es_read: assert property (s_rd_asleep ##0 (i_apb.paddr == can_pm_pkg::OFF_ES)
    |=> o_prdata == can_pm_pkg::ES_PD_READ) else $error("status read wrong in sleep");
  a_gate_discard: assert property (!o_module_clk_en |-> o_rx_discard)
    else $error("frames taken while gated");
  a_tx_holds_clk: assert property (o_module_clk_en && i_kernel.tx_busy |=> o_module_clk_en)
    else $error("sleep entered during frame");
  a_tx_holds_gbl: assert property (!o_global_clk_off && i_kernel.tx_busy |=> !o_global_clk_off)
    else $error("clocks off during frame");
  a_global_entry: assert property (i_system_low_power_request && !i_kernel.tx_busy
    |=> o_global_clk_off) else $error("clocks not stopped");
  a_global_exit: assert property (!i_system_low_power_request |=> !o_global_clk_off)
    else $error("clocks still stopped");
  a_done_clears: assert property (i_kernel.tx_done && !(i_apb.psel && i_apb.pwrite
    && i_apb.paddr == can_pm_pkg::OFF_TRS) |=> !o_transmit_request[$past(i_kernel.mb_idx)])
    else $error("request not cleared");
  a_wake_waits: assert property (!o_bus_active && o_module_clk_en && !i_kernel.bit_tick
    |=> !o_bus_active) else $error("bus active without bit");
  a_err_with_ready: assert property (o_pslverr |-> o_pready) else $error("stray slave error");
endmodule : can_pm_time_asserts

// *** dv/can_bus_node.sv ***
`timescale 1ns/1ps
module can_bus_node (
  input  wire logic i_ref_clk,
  input  wire logic i_rst,
  input  wire logic i_send,
  output logic      o_rx
);
  logic [3:0] cnt_reg;
  // Short dominant bursts model a frame start; released bus idles recessive
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_reg <= 4'h0;
    end else if (i_send) begin
      cnt_reg <= 4'hC;
    end else if (cnt_reg != 4'h0) begin
      cnt_reg <= cnt_reg - 4'h1;
    end
  end
  assign o_rx = (cnt_reg == 4'h0) | ~cnt_reg[1];
endmodule : can_bus_node

// *** dv/tb_can_pm_time.sv ***
`timescale 1ns/1ps
module tb_can_pm_time;
  typedef struct packed {logic [11:0] a; logic [31:0] d; logic [31:0] e; logic s;} row_t;
  logic                    i_ref_clk, i_rst, lpm, send, rx, rdy, err, clk_en, goff, bact, disc, change_config_request;
  can_pm_pkg::apb_req_t    apb;
  can_pm_pkg::kernel_evt_t kev;
  logic [31:0]             prd, transmit_request, rd;
  logic [1:0]              irq;
  logic                    se;
  int                      n_errors, num_checks;
  row_t rows [6] = '{'{12'h004, 32'h0001_0040, 32'h0001_0040, 1'b0},
    '{12'h04C, 32'hFFFF_0000, 32'hFFFF_0000, 1'b0}, '{12'h210, 32'hA5A5_5A5A, 32'hA5A5_5A5A, 1'b0},
    '{12'h104, 32'h1234_5678, 32'h1234_5678, 1'b0}, '{12'h030, 32'hFFFF_FFFF, 32'h0000_0000, 1'b0},
    '{12'h070, 32'h0000_0001, 32'h0000_0000, 1'b1}};
  can_pm_time dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_apb(apb), .i_kernel(kev),
    .i_bus_rx_pin(rx), .i_system_low_power_request(lpm), .o_prdata(prd), .o_pready(rdy),
    .o_pslverr(err), .o_module_clk_en(clk_en), .o_global_clk_off(goff), .o_bus_active(bact),
    .o_rx_discard(disc), .o_change_config_request(change_config_request), .o_transmit_request(transmit_request), .o_int_line(irq));
  can_bus_node node (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_send(send), .o_rx(rx));
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  task apb_x(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [2:0] p);
    @(posedge i_ref_clk);
    apb <= '{1'b1, 1'b0, w, a, d, p};
    @(posedge i_ref_clk);
    apb.penable <= 1'b1;
    // Unbounded wait; the watchdog catches a slave that never answers
    do @(posedge i_ref_clk); while (rdy !== 1'b1);
    rd = prd;
    se = err;
    apb <= '0;
  endtask : apb_x
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb_x(1'b1, a, d, 3'h1);
  endtask : wr
  task rdchk(input string what, input logic [11:0] a, input logic [31:0] e);
    apb_x(1'b0, a, 32'h0, 3'h1);
    check(what, rd, e);
  endtask : rdchk
  task cyc(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask : cyc
  task tick(input int n);
    repeat (n) begin
      @(posedge i_ref_clk) kev.bit_tick <= 1'b1;
      @(posedge i_ref_clk) kev.bit_tick <= 1'b0;
    end
  endtask : tick
  task pulse(input logic r, input logic [4:0] idx);
    @(posedge i_ref_clk);
    {kev.rx_store, kev.tx_done, kev.tx_ok, kev.mb_idx} <= {r, ~r, 1'b1, idx};
    @(posedge i_ref_clk);
    {kev.rx_store, kev.tx_done} <= 2'b00;
  endtask : pulse
  task burst;
    @(posedge i_ref_clk) send <= 1'b1;
    @(posedge i_ref_clk) send <= 1'b0;
    cyc(20);
  endtask : burst
  initial begin
    i_ref_clk = 1'b0;
    forever #50 i_ref_clk = ~i_ref_clk;
  end
  initial begin
    #3_000_000;
    n_errors++;
    complete_run();
  end
  initial begin
    {i_rst, lpm, send, apb, kev} = '0;
    i_rst = 1'b1;
    cyc(20);
    i_rst <= 1'b0;
    foreach (rows[i]) begin
      rdchk("reset value", rows[i].a, 32'h0000_0000);
      wr(rows[i].a, rows[i].d);
      check("slave error", {31'h0, se}, {31'h0, rows[i].s});
      rdchk("read back", rows[i].a, rows[i].e);
    end
    $display("register table done");
    apb_x(1'b1, can_pm_pkg::OFF_LNT, 32'hFFFF_FFF0, 3'h0);
    rdchk("time unprivileged", can_pm_pkg::OFF_LNT, 32'h0000_0000);
    wr(can_pm_pkg::OFF_LNT, 32'hFFFF_FFF0);
    wr(can_pm_pkg::OFF_MC, 32'h0000_4000);
    rdchk("time msb clear", can_pm_pkg::OFF_LNT, 32'h7FFF_FFF0);
    tick(16);
    rdchk("time count", can_pm_pkg::OFF_LNT, 32'h8000_0000);
    rdchk("overflow flag", can_pm_pkg::OFF_GIF0, 32'h0001_0000);
    wr(can_pm_pkg::OFF_GIF0, 32'h0001_0000);
    pulse(1'b1, 5'd3);
    rdchk("time stamp", 12'h10C, 32'h8000_0000);
    wr(can_pm_pkg::OFF_MC, 32'h0000_8000);
    pulse(1'b1, 5'd16);
    rdchk("sync clear", can_pm_pkg::OFF_LNT, 32'h0000_0000);
    $display("time counter done");
    wr(can_pm_pkg::OFF_GIM, 32'h0002_0001);
    wr(can_pm_pkg::OFF_TRS, 32'h0000_0020);
    wr(can_pm_pkg::OFF_TOC, 32'h0000_0020);
    cyc(40);
    rdchk("tx timeout", can_pm_pkg::OFF_TOS, 32'h0000_0020);
    check("alarm line", {30'h0, irq}, 32'h0000_0001);
    pulse(1'b0, 5'd5);
    rdchk("request cleared", can_pm_pkg::OFF_TRS, 32'h0000_0000);
    rdchk("tx timeout cleared", can_pm_pkg::OFF_TOS, 32'h0000_0000);
    wr(can_pm_pkg::OFF_TOC, 32'h0000_0040);
    cyc(40);
    rdchk("rx timeout", can_pm_pkg::OFF_TOS, 32'h0000_0040);
    wr(can_pm_pkg::OFF_TOC, 32'h0000_0000);
    rdchk("rx timeout off", can_pm_pkg::OFF_TOS, 32'h0000_0000);
    wr(can_pm_pkg::OFF_TOC, 32'h0000_0040);
    cyc(40);
    rdchk("rx timeout again", can_pm_pkg::OFF_TOS, 32'h0000_0040);
    wr(12'h218, 32'hFFFF_FFFF);
    wr(can_pm_pkg::OFF_TOS, 32'h0000_0040);
    rdchk("timeout w1c", can_pm_pkg::OFF_TOS, 32'h0000_0000);
    wr(can_pm_pkg::OFF_TOC, 32'h0000_0000);
    $display("time-out done");
    kev.tx_busy <= 1'b1;
    wr(can_pm_pkg::OFF_MC, 32'h0000_8A00);
    cyc(5);
    check("clock during frame", {31'h0, clk_en}, 32'h1);
    kev.tx_busy <= 1'b0;
    cyc(5);
    check("clock gated", {31'h0, clk_en}, 32'h0);
    rdchk("status asleep", can_pm_pkg::OFF_ES, 32'h0000_0008);
    rdchk("other asleep", can_pm_pkg::OFF_MD, 32'h0000_0000);
    burst();
    check("bus wake", {29'h0, clk_en, disc, bact}, 32'h6);
    tick(10);
    check("ten recessive", {31'h0, bact}, 32'h0);
    tick(1);
    cyc(2);
    check("eleven recessive", {31'h0, bact}, 32'h1);
    rdchk("control after wake", can_pm_pkg::OFF_MC, 32'h0000_8200);
    rdchk("status after wake", can_pm_pkg::OFF_ES, 32'h0000_0000);
    kev.bus_off <= 1'b1;
    wr(can_pm_pkg::OFF_MC, 32'h0000_8800);
    cyc(3);
    kev.bus_off <= 1'b0;
    burst();
    check("no bus wake", {31'h0, clk_en}, 32'h0);
    wr(can_pm_pkg::OFF_MC, 32'h0000_8000);
    cyc(3);
    check("request wake", {30'h0, clk_en, bact}, 32'h3);
    check("config request", {31'h0, change_config_request}, 32'h1);
    $display("local power-down done");
    kev.tx_busy <= 1'b1;
    lpm <= 1'b1;
    cyc(5);
    check("global during frame", {31'h0, goff}, 32'h0);
    kev.tx_busy <= 1'b0;
    cyc(3);
    check("global off", {31'h0, goff}, 32'h1);
    burst();
    lpm <= 1'b0;
    cyc(3);
    check("global on", {31'h0, goff}, 32'h0);
    rdchk("wake flag", can_pm_pkg::OFF_GIF0, 32'h0002_1000);
    $display("global power-down done");
    complete_run();
  end
endmodule : tb_can_pm_time
bind can_pm_time can_pm_time_asserts #(.NMB(NMB)) u_chk (.i_ref_clk(i_ref_clk),
  .i_rst(i_rst), .i_apb(i_apb), .i_kernel(i_kernel),
  .i_system_low_power_request(i_system_low_power_request), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .o_module_clk_en(o_module_clk_en),
  .o_global_clk_off(o_global_clk_off), .o_bus_active(o_bus_active),
  .o_rx_discard(o_rx_discard), .o_transmit_request(o_transmit_request));
